// ===== rtl/axsc_pkg.sv
// package of offsets, fields and timing constants for the auxiliary control register bank
package axsc_pkg;
  // ----------------------------------------
  // register offsets (byte address = 4 * index)
  // ----------------------------------------
  localparam logic [7:0] AXSC_IDX_OPERAND = 8'hF0;
  localparam logic [7:0] AXSC_IDX_SUM_LOW = 8'hF1;
  localparam logic [7:0] AXSC_IDX_SUM_HIGH = 8'hF2;
  localparam logic [7:0] AXSC_IDX_SUM_IN = 8'hF3;
  localparam logic [7:0] AXSC_IDX_REF_TRIM = 8'hF5;
  localparam logic [7:0] AXSC_IDX_OSC_TRIM = 8'hF6;
  localparam logic [7:0] AXSC_IDX_CTRL_TWO = 8'hF7;
  localparam logic [7:0] AXSC_IDX_CTRL_ONE = 8'hF8;
  localparam logic [7:0] AXSC_IDX_CFG_HIGH = 8'hF9;
  localparam logic [7:0] AXSC_IDX_CHAN_SEL = 8'hFA;
  localparam logic [7:0] AXSC_IDX_STATUS = 8'hFB;
  localparam int AXSC_ADDR_W = 10;
  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] AXSC_RST_OPERAND = 8'h00;
  localparam logic [7:0] AXSC_RST_SUM = 8'hFF;
  localparam logic [1:0] AXSC_RST_PROG_WD = 2'h3;
  localparam logic [1:0] AXSC_RST_WD_MODE = 2'h0;
  localparam logic [3:0] AXSC_RST_REF_TRIM = 4'h0;
  localparam logic [6:0] AXSC_RST_OSC_TRIM = 7'h40;
  localparam logic [7:0] AXSC_RST_CFG_HIGH = 8'h00;
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int AXSC_C1_WD_RESTART = 7;
  localparam int AXSC_C1_SLOW_CLEAR = 6;
  localparam int AXSC_C1_TOUCH = 5;
  localparam int AXSC_C1_CONV = 4;
  localparam int AXSC_C1_PWM_HOLD = 3;
  localparam int AXSC_C1_CNT2_SRC = 2;
  localparam int AXSC_C1_CNT1_SRC = 1;
  localparam int AXSC_C1_PTR_SEL = 0;
  localparam int AXSC_C2_WD_HI = 7;
  localparam int AXSC_C2_WD_LO = 6;
  localparam int AXSC_C2_PWR_SAVE = 5;
  localparam int AXSC_C2_REF_OUT = 4;
  localparam int AXSC_C2_PWD_HI = 2;
  localparam int AXSC_C2_PWD_LO = 1;
  localparam int AXSC_C2_LVR_OFF = 0;
  localparam int AXSC_CH_PROTECT = 7;
  localparam int AXSC_CH_XRESET = 6;
  localparam int AXSC_CH_LVL_HI = 5;
  localparam int AXSC_CH_LVL_LO = 3;
  localparam int AXSC_CH_TABLE_LOCK = 1;
  localparam logic [3:0] AXSC_REF_CHANNEL = 4'hB;
  // ----------------------------------------
  // watchdog and timing
  // ----------------------------------------
  localparam logic [1:0] AXSC_WD_RUN_ONLY = 2'h2;
  localparam logic [1:0] AXSC_WD_ALWAYS = 2'h3;
  localparam logic [1:0] AXSC_PWD_OFF = 2'h0;
  localparam logic [1:0] AXSC_PWD_SHORT = 2'h1;
  localparam logic [1:0] AXSC_PWD_MID = 2'h2;
  localparam int AXSC_CLK_HZ = 20_000_000;
  localparam int AXSC_PWD_SHORT_US = 900;
  localparam int AXSC_PWD_MID_US = 3600;
  localparam int AXSC_PWD_LONG_US = 7200;
  localparam int AXSC_PWD_SHORT_CYC = AXSC_PWD_SHORT_US * (AXSC_CLK_HZ / 1_000_000);
  localparam int AXSC_PWD_MID_CYC = AXSC_PWD_MID_US * (AXSC_CLK_HZ / 1_000_000);
  localparam int AXSC_PWD_LONG_CYC = AXSC_PWD_LONG_US * (AXSC_CLK_HZ / 1_000_000);
  localparam int AXSC_SLOW_DIV = 16;
  localparam logic [15:0] AXSC_SUM_POLY = 16'h1021;
endpackage

// ===== rtl/axsc_prog_watchdog.sv
// programming watchdog timer with selectable timeout
`timescale 1ns/100ps
module axsc_prog_watchdog #(
  parameter int SHORT_CYC = axsc_pkg::AXSC_PWD_SHORT_CYC,
  parameter int MID_CYC = axsc_pkg::AXSC_PWD_MID_CYC,
  parameter int LONG_CYC = axsc_pkg::AXSC_PWD_LONG_CYC
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [1:0] sel,
  input wire logic busy,
  output logic timeout
);
  logic [17:0] count_reg;
  logic [17:0] limit;

  // timeout length from the select code
  always_comb begin
    unique case (sel)
      axsc_pkg::AXSC_PWD_SHORT: limit = 18'(SHORT_CYC);
      axsc_pkg::AXSC_PWD_MID: limit = 18'(MID_CYC);
      default: limit = 18'(LONG_CYC);
    endcase
  end

  // counts while a program write is busy, flags timeout at limit
  always_ff @(posedge sys_clk) begin
    if (!rst_n || !busy || sel == axsc_pkg::AXSC_PWD_OFF) begin
      count_reg <= 18'h00000;
      timeout <= 1'b0;
    end else if (count_reg >= limit - 18'h00001) begin
      timeout <= 1'b1;
    end else begin
      count_reg <= count_reg + 18'h00001;
    end
  end
endmodule

// ===== rtl/axsc_regs.sv
// auxiliary system control register bank with avalon-mm slave
`timescale 1ns/100ps
module axsc_regs #(
  parameter int SHORT_CYC = axsc_pkg::AXSC_PWD_SHORT_CYC,
  parameter int MID_CYC = axsc_pkg::AXSC_PWD_MID_CYC,
  parameter int LONG_CYC = axsc_pkg::AXSC_PWD_LONG_CYC,
  parameter int SLOW_DIV = axsc_pkg::AXSC_SLOW_DIV
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [axsc_pkg::AXSC_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic run_mode,
  input wire logic prog_busy,
  input wire logic touch_done,
  input wire logic conv_done,
  input wire logic counter_two_pin,
  input wire logic counter_one_pin,
  input wire logic slow_clk_tick,
  output logic prog_timeout,
  output logic watchdog_enable,
  output logic watchdog_restart,
  output logic slow_timer_clear,
  output logic touch_start,
  output logic converter_start,
  output logic pwm_hold,
  output logic counter_two_tick,
  output logic counter_one_tick,
  output logic reference_pin_out,
  output logic [2:0] brownout_level_sel,
  output logic code_readout_lock,
  output logic ext_pin_reset_en,
  output logic table_read_lock,
  output logic [6:0] osc_freq_adjust,
  output logic [3:0] reference_trim_value
);
  // ----------------------------------------
  // storage
  // ----------------------------------------
  logic [7:0] operand_reg;
  logic [15:0] checksum_reg;
  logic [3:0] ref_trim_reg;
  logic [6:0] osc_trim_reg;
  logic [7:0] ctrl_one_reg;
  logic [7:0] ctrl_two_reg;
  logic [7:0] cfg_high_reg;
  logic [3:0] chan_sel_reg;
  logic [3:0] slow_div_reg;
  logic slow_tick_reg;
  logic ack_reg;
  logic wr_en;
  logic rd_en;
  logic [7:0] idx;
  logic [7:0] wbyte;
  logic [7:0] rbyte;
  logic [15:0] checksum_next;
  logic slow_div16;

  // byte-lane-0 write helper
  function automatic logic [7:0] axsc_merge(input logic [7:0] old_val, input logic [7:0] new_val,
                                            input logic lane);
    axsc_merge = lane ? new_val : old_val;
  endfunction

  // one checksum step for a whole byte
  function automatic logic [15:0] axsc_fold(input logic [15:0] crc, input logic [7:0] data);
    logic [15:0] c;
    c = crc ^ {data, 8'h00};
    for (int i = 0; i < 8; i++) begin
      c = c[15] ? ((c << 1) ^ axsc_pkg::AXSC_SUM_POLY) : (c << 1);
    end
    axsc_fold = c;
  endfunction

  // ----------------------------------------
  // avalon-mm slave
  // ----------------------------------------
  // every access takes one wait cycle, then completes
  assign avs_waitrequest = (avs_read || avs_write) && !ack_reg;
  assign idx = avs_address[axsc_pkg::AXSC_ADDR_W-1:2];
  assign wbyte = avs_writedata[7:0];
  assign wr_en = avs_write && ack_reg && avs_byteenable[0];
  assign rd_en = avs_read && !ack_reg;

  // ack toggles so each request sees one wait cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read || avs_write) && !ack_reg;
    end
  end

  // read mux; unmapped and write-only read zero
  always_comb begin
    unique case (idx)
      axsc_pkg::AXSC_IDX_OPERAND: rbyte = operand_reg;
      axsc_pkg::AXSC_IDX_SUM_LOW: rbyte = checksum_reg[7:0];
      axsc_pkg::AXSC_IDX_SUM_HIGH: rbyte = checksum_reg[15:8];
      axsc_pkg::AXSC_IDX_REF_TRIM: rbyte = {4'h0, ref_trim_reg};
      axsc_pkg::AXSC_IDX_OSC_TRIM: rbyte = {1'b0, osc_trim_reg};
      axsc_pkg::AXSC_IDX_CTRL_TWO: rbyte = ctrl_two_reg;
      axsc_pkg::AXSC_IDX_CTRL_ONE: rbyte = ctrl_one_reg;
      axsc_pkg::AXSC_IDX_CFG_HIGH: rbyte = cfg_high_reg;
      axsc_pkg::AXSC_IDX_CHAN_SEL: rbyte = {4'h0, chan_sel_reg};
      axsc_pkg::AXSC_IDX_STATUS: rbyte = {7'h00, prog_timeout};
      default: rbyte = 8'h00;
    endcase
  end

  // read data registered, valid when waitrequest drops
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      avs_readdata <= 32'h00000000;
    end else if (rd_en) begin
      avs_readdata <= {24'h000000, rbyte};
    end
  end

  // ----------------------------------------
  // plain data registers
  // ----------------------------------------
  // second operand and channel select
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      operand_reg <= axsc_pkg::AXSC_RST_OPERAND;
      chan_sel_reg <= 4'h0;
    end else if (wr_en && idx == axsc_pkg::AXSC_IDX_OPERAND) begin
      operand_reg <= wbyte;
    end else if (wr_en && idx == axsc_pkg::AXSC_IDX_CHAN_SEL) begin
      chan_sel_reg <= wbyte[3:0];
    end
  end

  // trims and configuration word
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ref_trim_reg <= axsc_pkg::AXSC_RST_REF_TRIM;
      osc_trim_reg <= axsc_pkg::AXSC_RST_OSC_TRIM;
      cfg_high_reg <= axsc_pkg::AXSC_RST_CFG_HIGH;
    end else if (wr_en) begin
      if (idx == axsc_pkg::AXSC_IDX_REF_TRIM) begin
        ref_trim_reg <= wbyte[3:0];
      end
      if (idx == axsc_pkg::AXSC_IDX_OSC_TRIM) begin
        osc_trim_reg <= wbyte[6:0];
      end
      if (idx == axsc_pkg::AXSC_IDX_CFG_HIGH) begin
        cfg_high_reg <= axsc_merge(cfg_high_reg, wbyte, 1'b1);
      end
    end
  end

  // ----------------------------------------
  // checksum
  // ----------------------------------------
  assign checksum_next = axsc_fold(checksum_reg, wbyte);

  // preload either byte, or fold an input byte in
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      checksum_reg <= {axsc_pkg::AXSC_RST_SUM, axsc_pkg::AXSC_RST_SUM};
    end else if (wr_en) begin
      unique case (idx)
        axsc_pkg::AXSC_IDX_SUM_LOW: checksum_reg[7:0] <= wbyte;
        axsc_pkg::AXSC_IDX_SUM_HIGH: checksum_reg[15:8] <= wbyte;
        axsc_pkg::AXSC_IDX_SUM_IN: checksum_reg <= checksum_next;
        default: checksum_reg <= checksum_reg;
      endcase
    end
  end

  // ----------------------------------------
  // control register two
  // ----------------------------------------
  // bit 3 reserved and kept zero
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl_two_reg <= {axsc_pkg::AXSC_RST_WD_MODE, 3'h0, axsc_pkg::AXSC_RST_PROG_WD, 1'b0};
    end else if (wr_en && idx == axsc_pkg::AXSC_IDX_CTRL_TWO) begin
      ctrl_two_reg <= {wbyte[7:4], 1'b0, wbyte[2:0]};
    end
  end

  // ----------------------------------------
  // control register one
  // ----------------------------------------
  // pulse bits self-clear; a same-cycle write to control one wins over hardware done
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ctrl_one_reg <= 8'h00;
    end else if (wr_en && idx == axsc_pkg::AXSC_IDX_CTRL_ONE) begin
      ctrl_one_reg <= wbyte;
    end else begin
      ctrl_one_reg[axsc_pkg::AXSC_C1_WD_RESTART] <= 1'b0;
      ctrl_one_reg[axsc_pkg::AXSC_C1_SLOW_CLEAR] <= 1'b0;
      if (touch_done) begin
        ctrl_one_reg[axsc_pkg::AXSC_C1_TOUCH] <= 1'b0;
      end
      if (conv_done) begin
        ctrl_one_reg[axsc_pkg::AXSC_C1_CONV] <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // slow clock divider for counter inputs
  // ----------------------------------------
  assign slow_div16 = slow_clk_tick && (slow_div_reg == 4'(SLOW_DIV - 1));

  // one tick out of sixteen slow ticks
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      slow_div_reg <= 4'h0;
      slow_tick_reg <= 1'b0;
    end else begin
      slow_tick_reg <= slow_div16;
      if (slow_clk_tick) begin
        slow_div_reg <= slow_div16 ? 4'h0 : slow_div_reg + 4'h1;
      end
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // watchdog mode decode
  always_comb begin
    unique case (ctrl_two_reg[axsc_pkg::AXSC_C2_WD_HI:axsc_pkg::AXSC_C2_WD_LO])
      axsc_pkg::AXSC_WD_ALWAYS: watchdog_enable = 1'b1;
      axsc_pkg::AXSC_WD_RUN_ONLY: watchdog_enable = run_mode;
      default: watchdog_enable = 1'b0;
    endcase
  end

  assign watchdog_restart = ctrl_one_reg[axsc_pkg::AXSC_C1_WD_RESTART];
  assign slow_timer_clear = ctrl_one_reg[axsc_pkg::AXSC_C1_SLOW_CLEAR];
  assign touch_start = ctrl_one_reg[axsc_pkg::AXSC_C1_TOUCH];
  assign converter_start = ctrl_one_reg[axsc_pkg::AXSC_C1_CONV];
  assign pwm_hold = ctrl_one_reg[axsc_pkg::AXSC_C1_PWM_HOLD];
  // counter source selects
  assign counter_two_tick = ctrl_one_reg[axsc_pkg::AXSC_C1_CNT2_SRC] ? slow_tick_reg : counter_two_pin;
  assign counter_one_tick = ctrl_one_reg[axsc_pkg::AXSC_C1_CNT1_SRC] ? slow_tick_reg : counter_one_pin;
  // reference output only on the matching channel
  assign reference_pin_out = ctrl_two_reg[axsc_pkg::AXSC_C2_REF_OUT]
                             && (chan_sel_reg == axsc_pkg::AXSC_REF_CHANNEL);
  // configuration word fields
  assign brownout_level_sel = cfg_high_reg[axsc_pkg::AXSC_CH_LVL_HI:axsc_pkg::AXSC_CH_LVL_LO];
  assign code_readout_lock = cfg_high_reg[axsc_pkg::AXSC_CH_PROTECT];
  assign ext_pin_reset_en = cfg_high_reg[axsc_pkg::AXSC_CH_XRESET];
  assign table_read_lock = cfg_high_reg[axsc_pkg::AXSC_CH_TABLE_LOCK];
  assign osc_freq_adjust = osc_trim_reg;
  assign reference_trim_value = ref_trim_reg;

  // ----------------------------------------
  // programming watchdog
  // ----------------------------------------
  axsc_prog_watchdog #(
    .SHORT_CYC(SHORT_CYC),
    .MID_CYC(MID_CYC),
    .LONG_CYC(LONG_CYC)
  ) u_prog_wd (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .sel(ctrl_two_reg[axsc_pkg::AXSC_C2_PWD_HI:axsc_pkg::AXSC_C2_PWD_LO]),
    .busy(prog_busy),
    .timeout(prog_timeout)
  );
endmodule

// ===== test/axsc_regs_properties.sv
// concurrent properties for the auxiliary control register bank
`timescale 1ns/100ps
module axsc_regs_checker (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [axsc_pkg::AXSC_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  input wire logic run_mode,
  input wire logic touch_done,
  input wire logic conv_done,
  input wire logic counter_two_pin,
  input wire logic counter_one_pin,
  input wire logic prog_timeout,
  input wire logic watchdog_enable,
  input wire logic watchdog_restart,
  input wire logic slow_timer_clear,
  input wire logic touch_start,
  input wire logic converter_start,
  input wire logic pwm_hold,
  input wire logic counter_two_tick,
  input wire logic counter_one_tick,
  input wire logic reference_pin_out,
  input wire logic [2:0] brownout_level_sel,
  input wire logic code_readout_lock,
  input wire logic ext_pin_reset_en,
  input wire logic table_read_lock
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // shadow copies of written fields
  // ----------------------------------------
  logic taken, wr_c1;
  logic [7:0] idx, c1_reg, c2_reg, cfg_reg;
  logic [3:0] chan_reg;
  // a write lands at the edge where waitrequest is low
  assign idx = avs_address[9:2];
  assign taken = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign wr_c1 = taken && idx == 8'hF8;
  // shadow registers follow accepted writes
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      c1_reg <= 8'h00;
      c2_reg <= 8'h06;
      cfg_reg <= 8'h00;
      chan_reg <= 4'h0;
    end else if (taken) begin
      if (idx == 8'hF8) c1_reg <= avs_writedata[7:0];
      if (idx == 8'hF7) c2_reg <= avs_writedata[7:0];
      if (idx == 8'hF9) cfg_reg <= avs_writedata[7:0];
      if (idx == 8'hFA) chan_reg <= avs_writedata[3:0];
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest longer than one cycle");
  AST_WD_MODE: assert property (watchdog_enable == (c2_reg[7] && (c2_reg[6] || run_mode)))
    else $error("watchdog enable decode wrong");
  AST_RESTART: assert property (wr_c1 && avs_writedata[7] |=> watchdog_restart ##1 !watchdog_restart)
    else $error("watchdog restart not a one cycle pulse");
  AST_SLOW_CLR: assert property (wr_c1 && avs_writedata[6] |=> slow_timer_clear ##1 !slow_timer_clear)
    else $error("slow timer clear not a one cycle pulse");
  AST_TOUCH_END: assert property (touch_done && !wr_c1 |=> !touch_start)
    else $error("touch start not cleared at end");
  AST_CONV_GO: assert property (wr_c1 && avs_writedata[4] |=> converter_start)
    else $error("converter start not set");
  AST_CONV_END: assert property (conv_done && !wr_c1 |=> !converter_start)
    else $error("converter start not cleared at end");
  AST_PWM: assert property (pwm_hold == c1_reg[3])
    else $error("pwm hold mismatch");
  AST_CNT_PIN: assert property ((c1_reg[2] || counter_two_tick == counter_two_pin) &&
    (c1_reg[1] || counter_one_tick == counter_one_pin))
    else $error("counter source not the pin");
  AST_REF_OUT: assert property (reference_pin_out == (c2_reg[4] && chan_reg == 4'hB))
    else $error("reference pin output mismatch");
  AST_CFG: assert property ({code_readout_lock, ext_pin_reset_en, brownout_level_sel,
    table_read_lock} == {cfg_reg[7:3], cfg_reg[1]})
    else $error("config word outputs mismatch");
  // main scenarios reached
  COV_RESTART: cover property (wr_c1 && avs_writedata[7]);
  COV_CONV_END: cover property (conv_done && converter_start);
  COV_TIMEOUT: cover property ($rose(prog_timeout));
endmodule
bind axsc_regs axsc_regs_checker u_chk (.sys_clk(sys_clk), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_waitrequest(avs_waitrequest), .run_mode(run_mode), .touch_done(touch_done), .conv_done(conv_done),
  .counter_two_pin(counter_two_pin), .counter_one_pin(counter_one_pin), .prog_timeout(prog_timeout),
  .watchdog_enable(watchdog_enable), .watchdog_restart(watchdog_restart), .slow_timer_clear(slow_timer_clear),
  .touch_start(touch_start), .converter_start(converter_start), .pwm_hold(pwm_hold),
  .counter_two_tick(counter_two_tick), .counter_one_tick(counter_one_tick),
  .reference_pin_out(reference_pin_out), .brownout_level_sel(brownout_level_sel),
  .code_readout_lock(code_readout_lock), .ext_pin_reset_en(ext_pin_reset_en), .table_read_lock(table_read_lock));

// ===== test/axsc_regs_test.sv
// self-checking testbench for the auxiliary control register bank
`timescale 1ns/100ps
module axsc_regs_test;
  localparam int SHORT = 10;
  localparam int MID = 20;
  localparam int LONG = 40;
  logic sys_clk = 1'b0, rst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
  logic [9:0] avs_address = 10'h000;
  logic [31:0] avs_writedata = 32'h00000000, avs_readdata;
  logic [3:0] avs_byteenable = 4'h0;
  logic run_mode = 1'b0, prog_busy = 1'b0, touch_done = 1'b0, conv_done = 1'b0, slow_clk_tick = 1'b0;
  logic counter_two_pin = 1'b0, counter_one_pin = 1'b0;
  logic prog_timeout, watchdog_enable, watchdog_restart, slow_timer_clear, touch_start, converter_start;
  logic pwm_hold, counter_two_tick, counter_one_tick, reference_pin_out, code_readout_lock;
  logic ext_pin_reset_en, table_read_lock;
  logic [2:0] brownout_level_sel;
  logic [6:0] osc_freq_adjust;
  logic [3:0] reference_trim_value;
  int n_fail = 0, checks_done = 0;
  // clock at 20 MHz
  always #25 sys_clk = ~sys_clk;
  axsc_regs #(.SHORT_CYC(SHORT), .MID_CYC(MID), .LONG_CYC(LONG)) dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .run_mode(run_mode), .prog_busy(prog_busy), .touch_done(touch_done), .conv_done(conv_done),
    .counter_two_pin(counter_two_pin), .counter_one_pin(counter_one_pin), .slow_clk_tick(slow_clk_tick),
    .prog_timeout(prog_timeout), .watchdog_enable(watchdog_enable), .watchdog_restart(watchdog_restart),
    .slow_timer_clear(slow_timer_clear), .touch_start(touch_start), .converter_start(converter_start),
    .pwm_hold(pwm_hold), .counter_two_tick(counter_two_tick), .counter_one_tick(counter_one_tick),
    .reference_pin_out(reference_pin_out), .brownout_level_sel(brownout_level_sel),
    .code_readout_lock(code_readout_lock), .ext_pin_reset_en(ext_pin_reset_en),
    .table_read_lock(table_read_lock), .osc_freq_adjust(osc_freq_adjust),
    .reference_trim_value(reference_trim_value));
  // ----------------------------------------
  // bus and compare tasks
  // ----------------------------------------
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d, input logic [3:0] be,
                     output logic [7:0] rd);
    logic w;
    @(posedge sys_clk);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h000000, d};
    avs_byteenable <= be;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(negedge sys_clk);
      w = avs_waitrequest;
      rd = avs_readdata[7:0];
      @(posedge sys_clk);
    end while (w !== 1'b0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] r;
    bus(1'b1, idx, d, 4'h1, r);
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] r;
    bus(1'b0, idx, 8'h00, 4'hF, r);
    cmp(16'(r), 16'(exp));
  endtask
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {b, 8'h00};
    for (int i = 0; i < 8; i++) r = r[15] ? ((r << 1) ^ 16'h1021) : (r << 1);
    return r;
  endfunction
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    logic [7:0] r;
    logic [15:0] e;
    rdc(8'hF1, 8'hFF);
    rdc(8'hF2, 8'hFF);
    rdc(8'hF7, 8'h06);
    wr(8'hF0, 8'hA5);
    bus(1'b1, 8'hF0, 8'h5A, 4'h0, r);
    rdc(8'hF0, 8'hA5);
    wr(8'h10, 8'h55);
    rdc(8'h10, 8'h00);
    rdc(8'hF3, 8'h00);
    wr(8'hF5, 8'hFF);
    rdc(8'hF5, 8'h0F);
    wr(8'hF6, 8'hFF);
    rdc(8'hF6, 8'h7F);
    cmp(16'({osc_freq_adjust, reference_trim_value}), 16'h07FF);
    wr(8'hF1, 8'h34);
    wr(8'hF2, 8'h12);
    rdc(8'hF1, 8'h34);
    e = 16'h1234;
    for (int i = 0; i < 2; i++) begin
      wr(8'hF3, 8'h31 + 8'(i) * 8'h96);
      e = crc_step(e, 8'h31 + 8'(i) * 8'h96);
    end
    rdc(8'hF1, e[7:0]);
    rdc(8'hF2, e[15:8]);
    $display("test registers done");
  endtask
  task automatic t_ctrl;
    int n2, n1;
    wr(8'hF8, 8'hC0);
    @(negedge sys_clk);
    cmp(16'({watchdog_restart, slow_timer_clear}), 16'h0003);
    rdc(8'hF8, 8'h00);
    wr(8'hF8, 8'h30);
    @(negedge sys_clk);
    cmp(16'({touch_start, converter_start}), 16'h0003);
    @(posedge sys_clk);
    conv_done <= 1'b1;
    @(posedge sys_clk);
    conv_done <= 1'b0;
    touch_done <= 1'b1;
    @(negedge sys_clk);
    cmp(16'({touch_start, converter_start}), 16'h0002);
    @(posedge sys_clk);
    touch_done <= 1'b0;
    @(negedge sys_clk);
    cmp(16'(touch_start), 16'h0000);
    wr(8'hF8, 8'h30);
    wr(8'hF8, 8'h08);
    @(negedge sys_clk);
    cmp(16'({touch_start, converter_start, pwm_hold}), 16'h0001);
    @(posedge sys_clk);
    counter_two_pin <= 1'b1;
    @(negedge sys_clk);
    cmp(16'({counter_two_tick, counter_one_tick}), 16'h0002);
    @(posedge sys_clk);
    counter_two_pin <= 1'b0;
    counter_one_pin <= 1'b1;
    @(negedge sys_clk);
    cmp(16'({counter_two_tick, counter_one_tick}), 16'h0001);
    wr(8'hF8, 8'h06);
    n2 = 0;
    n1 = 0;
    repeat (96) begin
      @(posedge sys_clk);
      slow_clk_tick <= !slow_clk_tick;
      @(negedge sys_clk);
      n2 += int'(counter_two_tick === 1'b1);
      n1 += int'(counter_one_tick === 1'b1);
    end
    cmp(16'(n2), 16'h0003);
    cmp(16'(n1), 16'h0003);
    cmp(16'(pwm_hold), 16'h0000);
    $display("test control one done");
  endtask
  task automatic t_ctrl2;
    int lim;
    for (int m = 0; m < 8; m++) begin
      wr(8'hF7, {m[2:1], 6'h06});
      run_mode <= m[0];
      @(negedge sys_clk);
      cmp(16'(watchdog_enable), 16'(m[2] && (m[1] || m[0])));
    end
    wr(8'hFA, 8'h0B);
    wr(8'hF7, 8'h16);
    @(negedge sys_clk);
    cmp(16'(reference_pin_out), 16'h0001);
    wr(8'hFA, 8'h0A);
    @(negedge sys_clk);
    cmp(16'(reference_pin_out), 16'h0000);
    // for selects 1 to 3 timeout must rise exactly at the lim-th busy edge, for select 0 not at all
    for (int s = 0; s < 4; s++) begin
      lim = (s == 1) ? SHORT : (s == 2) ? MID : (s == 3) ? LONG : 2 * LONG;
      wr(8'hF7, {5'h00, 2'(s), 1'b0});
      prog_busy <= 1'b1;
      repeat (lim - 1) @(posedge sys_clk);
      @(negedge sys_clk);
      cmp(16'(prog_timeout), 16'h0000);
      @(negedge sys_clk);
      cmp(16'(prog_timeout), 16'(s != 0));
      rdc(8'hFB, (s == 0) ? 8'h00 : 8'h01);
      prog_busy <= 1'b0;
      repeat (3) @(posedge sys_clk);
      @(negedge sys_clk);
      cmp(16'(prog_timeout), 16'h0000);
    end
    for (int lv = 0; lv < 8; lv++) begin
      wr(8'hF9, {2'b11, 3'(lv), 3'b010});
      @(negedge sys_clk);
      cmp(16'({code_readout_lock, ext_pin_reset_en, brownout_level_sel, table_read_lock}),
          16'({2'b11, 3'(lv), 1'b1}));
    end
    wr(8'hF9, 8'h00);
    @(negedge sys_clk);
    cmp(16'({code_readout_lock, ext_pin_reset_en, table_read_lock}), 16'h0000);
    $display("test control two and config done");
  endtask
  // ----------------------------------------
  // run control
  // ----------------------------------------
  task automatic report_and_stop;
    $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // watchdog against a hung handshake
  initial begin
    #(50 * 20000);
    n_fail++;
    report_and_stop();
  end
  // main sequence
  initial begin
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_regs();
    t_ctrl();
    t_ctrl2();
    report_and_stop();
  end
endmodule
